/* File: include/drive_cmd_pkg.sv */
package drive_cmd_pkg;
	// Clock and tick timing
	localparam int CLK_PERIOD_NS = 4;
	localparam int TICK_PERIOD_MS = 1;
	localparam int NS_PER_MS = 1000000;
	localparam int TICK_CYCLES = TICK_PERIOD_MS * NS_PER_MS / CLK_PERIOD_NS;
	localparam int LOCKOUT_MS = 200;
	localparam int OVERLOAD_S = 60;
	localparam int MS_PER_S = 1000;
	// Least time, so round up
	localparam int LOCKOUT_TICKS = (LOCKOUT_MS + TICK_PERIOD_MS - 1) / TICK_PERIOD_MS;
	localparam int OVERLOAD_TICKS = OVERLOAD_S * MS_PER_S / TICK_PERIOD_MS;
	localparam logic [15:0] LOCK_LAST = 16'(LOCKOUT_TICKS - 1);
	localparam logic [15:0] OL_LAST = 16'(OVERLOAD_TICKS - 1);
	// Frequency format: unsigned, 0.01 Hz per count
	localparam int FREQ_W = 16;
	localparam logic [16:0] WAKE_HYST = 17'h000C8;
	localparam logic [31:0] TRIP_LOAD_PCT = 32'h00000096;
	localparam logic [31:0] PCT_DIV = 32'h00000064;
	localparam logic [2:0] HZ_DECIMALS = 3'h2;
	// Register byte offsets
	localparam logic [7:0] ADR_CTRL = 8'h00;
	localparam logic [7:0] ADR_DISP = 8'h04;
	localparam logic [7:0] ADR_RATES = 8'h08;
	localparam logic [7:0] ADR_SLEEP = 8'h0C;
	localparam logic [7:0] ADR_PRE12 = 8'h10;
	localparam logic [7:0] ADR_PRE34 = 8'h14;
	localparam logic [7:0] ADR_LOAD = 8'h18;
	localparam logic [7:0] ADR_STATUS = 8'h1C;
	localparam logic [7:0] ADR_FREQ = 8'h20;
	localparam logic [7:0] ADR_VALUE = 8'h24;
	// Control, display and status register field positions
	localparam int CTL_STOP = 0;
	localparam int CTL_DIR = 2;
	localparam int CTL_METHOD = 4;
	localparam int CTL_MANSRC = 6;
	localparam int CTL_SRC = 7;
	localparam int CTL_FN1 = 9;
	localparam int CTL_FN2 = 12;
	localparam int CTL_REVFN = 15;
	localparam int CTL_PID = 18;
	localparam int CTL_UNITS = 19;
	localparam int DSP_DP = 16;
	localparam int ST_TRIP_BIT = 3;
	// Reset values
	localparam logic [31:0] CTRL_RST = 32'h00000000;
	localparam logic [31:0] DISP_RST = 32'h00000064;
	localparam logic [31:0] RATES_RST = 32'h00010001;
	localparam logic [31:0] ZERO_RST = 32'h00000000;
	localparam logic [31:0] LOAD_RST = 32'h00000064;
	// Setting encodings
	typedef enum logic [1:0] {STOP_COAST = 2'h0, STOP_RAMP = 2'h1, STOP_RAMP2 = 2'h2} stop_mode_t;
	typedef enum logic [1:0] {DIR_FWD = 2'h0, DIR_REV = 2'h1, DIR_BOTH = 2'h2,
		DIR_FWD_LOCAL = 2'h3} dir_limit_t;
	typedef enum logic [1:0] {SPD_MANUAL = 2'h0, SPD_AUTO = 2'h1, SPD_BOTH = 2'h2} method_t;
	typedef enum logic [1:0] {SRC_LOCAL = 2'h0, SRC_REMOTE = 2'h1, SRC_BOTH = 2'h2} cmd_src_t;
	typedef enum logic [2:0] {FN_NONE = 3'h0, FN_VOLT = 3'h1, FN_CURRENT = 3'h2,
		FN_PRESET = 3'h3, FN_LOCAL_SEL = 3'h4, FN_RUN_BACKWARD_ASSIGNMENT = 3'h5, FN_START_REV = 3'h6} fn_t;
	typedef enum logic [2:0] {U_HERTZ = 3'h0, U_PCT_HZ = 3'h1, U_SPEED = 3'h2,
		U_PROC_PCT = 3'h3, U_PROC = 3'h4} units_t;
	typedef enum logic [4:0] {ST_STOP = 5'h01, ST_RUN = 5'h02, ST_STOPPING = 5'h04,
		ST_LOCKOUT = 5'h08, ST_SLEEP = 5'h10} state_t;
endpackage : drive_cmd_pkg

/* File: include/ramp_if.sv */
`timescale 1ns/1ns
interface ramp_if;
	import drive_cmd_pkg::*;
	logic tick; // Rate tick
	logic cut; // Output off, frequency to zero at once
	logic [FREQ_W-1:0] target; // Frequency to ramp towards
	logic [FREQ_W-1:0] up_rate; // Counts per tick, rising
	logic [FREQ_W-1:0] dn_rate; // Counts per tick, falling
	logic [FREQ_W-1:0] freq; // Present output frequency
	logic at_zero; // Output frequency is zero
	modport ctrl (output tick, cut, target, up_rate, dn_rate, input freq, at_zero);
	modport ramp (input tick, cut, target, up_rate, dn_rate, output freq, at_zero);
endinterface : ramp_if

/* File: rtl/freq_ramp.sv */
`timescale 1ns/1ns
module freq_ramp import drive_cmd_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Ramp control
	ramp_if.ramp rp
);
	logic [FREQ_W-1:0] freq_q; // Output frequency
	logic [FREQ_W-1:0] freq_d;

	// Step towards target once per tick; never overshoot it
	always_comb begin
		freq_d = freq_q;
		if (rp.cut) begin
			freq_d = '0;
		end else if (rp.tick && freq_q < rp.target) begin
			freq_d = (rp.target - freq_q > rp.up_rate) ? freq_q + rp.up_rate : rp.target;
		end else if (rp.tick && freq_q > rp.target) begin
			freq_d = (freq_q - rp.target > rp.dn_rate) ? freq_q - rp.dn_rate : rp.target;
		end
	end

	// Frequency register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			freq_q <= '0;
		end else begin
			freq_q <= freq_d;
		end
	end

	assign rp.freq = freq_q;
	assign rp.at_zero = (freq_q == '0);
endmodule : freq_ramp

/* File: rtl/drive_command_and_sleep_control.sv */
// Decided for this implementation: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ns
module drive_command_and_sleep_control import drive_cmd_pkg::*; #(
	parameter int TICK_CYCLES_P = TICK_CYCLES
) (
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic RST_N,
	// Wishbone slave
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [7:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	// Keypad, one-cycle key pulses
	input wire logic KEY_START,
	input wire logic KEY_STOP,
	input wire logic KEY_DIRECTION,
	input wire logic KEY_AUTO_MANUAL,
	input wire logic [15:0] KEY_SPEED,
	// Terminal strip, high while closed to common
	input wire logic FORWARD_RUN_INPUT,
	input wire logic REVERSE_FUNCTION_INPUT,
	input wire logic FIRST_FUNCTION_INPUT,
	input wire logic SECOND_FUNCTION_INPUT,
	input wire logic TERMINAL_HALT_INPUT,
	// Conditioned references and load
	input wire logic [15:0] VOLTAGE_SPEED_INPUT,
	input wire logic [15:0] CURRENT_LOOP_SPEED_INPUT,
	input wire logic [15:0] LOAD_PERCENT,
	// Drive command and indication
	output logic MOTOR_ENABLE,
	output logic [15:0] OUTPUT_FREQ,
	output logic OUTPUT_REVERSE,
	output logic SLEEP_ACTIVE,
	output logic OVERLOAD_TRIP,
	output logic LOCAL_ACTIVE,
	output logic AUTO_ACTIVE,
	output logic [31:0] DISPLAY_VALUE,
	output logic [2:0] DISPLAY_DECIMAL,
	output logic [2:0] DISPLAY_UNITS
);
	localparam int PRE_W = $clog2(TICK_CYCLES_P);
	localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYCLES_P - 1);

	// A prescaler of one cycle cannot make a pulse train
	if (TICK_CYCLES_P < 2) begin : g_chk
		$error("TICK_CYCLES_P must be at least 2");
	end

	// Byte-lane merge for register writes
	function automatic logic [31:0] wb_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) r[8*i +: 8] = wd[8*i +: 8];
		end
		return r;
	endfunction : wb_merge

	ramp_if rp ();

	// Register file and bus state
	logic [31:0] ctrl_q, ctrl_d, disp_q, disp_d, rates_q, rates_d, sleep_q, sleep_d;
	logic [31:0] pre12_q, pre12_d, pre34_q, pre34_d, load_q, load_d;
	logic ack_q, ack_d; // Answer, one cycle
	logic [31:0] rdat_q, rdat_d; // Read data
	// Control state
	state_t state_q, state_d;
	logic out_rev_q, out_rev_d; // Direction driven to the motor
	logic dir_req_q, dir_req_d; // Keypad direction choice
	logic auto_q, auto_d; // Auto speed control active
	logic trip_q, trip_d; // Overload trip, sticky
	logic local_q, local_d;
	logic sleep_out_q, sleep_out_d;
	logic motor_q, motor_d;
	logic fwd_prev_q, fwd_prev_d, rev_prev_q, rev_prev_d; // Edge detect of run inputs
	logic [PRE_W-1:0] pre_q, pre_d; // Tick prescaler
	logic tick_q, tick_d;
	logic [15:0] lock_cnt_q, lock_cnt_d, sleep_cnt_q, sleep_cnt_d, ol_cnt_q, ol_cnt_d;
	logic [31:0] dval_q, dval_d;
	logic [2:0] ddp_q, ddp_d, dunit_q, dunit_d;

	// Decoded settings
	stop_mode_t stop_mode;
	dir_limit_t dir_lim;
	method_t method;
	cmd_src_t cmd_src;
	fn_t fn1, fn2, rev_fn;
	units_t units, eff_units;
	logic pid_en, man_volt;
	assign stop_mode = stop_mode_t'(ctrl_q[CTL_STOP +: 2]);
	assign dir_lim = dir_limit_t'(ctrl_q[CTL_DIR +: 2]);
	assign method = method_t'(ctrl_q[CTL_METHOD +: 2]);
	assign man_volt = ctrl_q[CTL_MANSRC];
	assign cmd_src = cmd_src_t'(ctrl_q[CTL_SRC +: 2]);
	assign fn1 = fn_t'(ctrl_q[CTL_FN1 +: 3]);
	assign fn2 = fn_t'(ctrl_q[CTL_FN2 +: 3]);
	assign rev_fn = fn_t'(ctrl_q[CTL_REVFN +: 3]);
	assign pid_en = ctrl_q[CTL_PID];
	assign units = units_t'(ctrl_q[CTL_UNITS +: 3]);

	// Command decode
	logic local_mode, rev_assigned, remote_rev, dir_want, halt_en;
	logic start_req, stop_req, start_ok, over, ol_fire;
	logic [15:0] man_ref, cmd_speed, thresh;
	logic [16:0] wake_lvl;
	logic [31:0] scaled_load;
	always_comb begin
		// Local select from the first or the reverse function input
		local_mode = (cmd_src == SRC_LOCAL) || (cmd_src == SRC_BOTH &&
			((fn1 == FN_LOCAL_SEL && FIRST_FUNCTION_INPUT) ||
			(rev_fn == FN_LOCAL_SEL && REVERSE_FUNCTION_INPUT)));
		rev_assigned = (rev_fn == FN_RUN_BACKWARD_ASSIGNMENT) || (rev_fn == FN_START_REV);
		remote_rev = rev_assigned && REVERSE_FUNCTION_INPUT;
		// Run-reverse makes the halt input dead in remote mode
		halt_en = !local_mode && (rev_fn != FN_RUN_BACKWARD_ASSIGNMENT);
		if (local_mode) begin
			start_req = KEY_START;
			stop_req = KEY_STOP;
		end else begin
			start_req = (FORWARD_RUN_INPUT && !fwd_prev_q) || (remote_rev && !rev_prev_q);
			stop_req = (halt_en && !TERMINAL_HALT_INPUT) ||
				(!halt_en && !FORWARD_RUN_INPUT && !remote_rev);
		end
		// Direction wanted after the limit
		case (dir_lim)
			DIR_FWD: dir_want = 1'b0;
			DIR_REV: dir_want = 1'b1;
			DIR_BOTH: dir_want = local_mode ? dir_req_q : remote_rev;
			DIR_FWD_LOCAL: dir_want = local_mode ? 1'b0 : remote_rev;
			default: dir_want = 1'b0;
		endcase
		// Reverse-only from terminals needs a reverse assignment
		start_ok = start_req && !trip_q && !(dir_lim == DIR_REV && !local_mode &&
			!rev_assigned);
		// Speed reference selection
		man_ref = man_volt ? VOLTAGE_SPEED_INPUT : KEY_SPEED;
		cmd_speed = man_ref;
		if (auto_q) begin
			if (fn1 == FN_PRESET && FIRST_FUNCTION_INPUT && fn2 == FN_PRESET &&
				SECOND_FUNCTION_INPUT) cmd_speed = pre34_q[31:16];
			else if (fn1 == FN_PRESET && FIRST_FUNCTION_INPUT) cmd_speed = pre12_q[15:0];
			else if (fn2 == FN_PRESET && SECOND_FUNCTION_INPUT) cmd_speed = pre12_q[31:16];
			else if (rev_fn == FN_PRESET && REVERSE_FUNCTION_INPUT) cmd_speed = pre34_q[15:0];
			else if ((fn1 == FN_VOLT && FIRST_FUNCTION_INPUT) ||
				(fn2 == FN_VOLT && SECOND_FUNCTION_INPUT)) cmd_speed = VOLTAGE_SPEED_INPUT;
			else if ((fn1 == FN_CURRENT && FIRST_FUNCTION_INPUT) ||
				(fn2 == FN_CURRENT && SECOND_FUNCTION_INPUT))
				cmd_speed = CURRENT_LOOP_SPEED_INPUT;
		end
		// All speed compares share the 0.01 Hz format
		thresh = sleep_q[15:0];
		wake_lvl = {1'b0, thresh} + WAKE_HYST;
		scaled_load = 32'(LOAD_PERCENT * load_q[15:0]) / PCT_DIV;
		over = scaled_load >= TRIP_LOAD_PCT;
		ol_fire = over && tick_q && ol_cnt_q == OL_LAST;
		// Effective display units
		eff_units = units;
		if (units >= U_PROC_PCT && !(pid_en && auto_q)) eff_units = U_HERTZ;
		else if (units < U_PROC_PCT && pid_en && auto_q) eff_units = U_PROC_PCT;
	end

	// Ramp connection: cut and target follow the next state
	assign rp.tick = tick_q;
	assign rp.cut = (state_d == ST_STOP) || (state_d == ST_LOCKOUT);
	assign rp.target = (state_d == ST_RUN && out_rev_q == dir_want) ? cmd_speed : '0;
	assign rp.up_rate = rates_q[15:0];
	assign rp.dn_rate = rates_q[31:16];

	freq_ramp u_ramp (
		.clk(SYS_CLK),
		.rst_n(RST_N),
		.rp(rp.ramp)
	);

	// Next values of bus, command and timer state
	always_comb begin
		ctrl_d = ctrl_q;
		disp_d = disp_q;
		rates_d = rates_q;
		sleep_d = sleep_q;
		pre12_d = pre12_q;
		pre34_d = pre34_q;
		load_d = load_q;
		ack_d = 1'b0;
		rdat_d = rdat_q;
		trip_d = trip_q;
		// Bus: one wait state, ack dropped the cycle after
		if (WB_CYC_I && WB_STB_I && !ack_q) begin
			ack_d = 1'b1;
			rdat_d = 32'h00000000; // Unmapped reads zero
			case (WB_ADR_I)
				ADR_CTRL: rdat_d = ctrl_q;
				ADR_DISP: rdat_d = disp_q;
				ADR_RATES: rdat_d = rates_q;
				ADR_SLEEP: rdat_d = sleep_q;
				ADR_PRE12: rdat_d = pre12_q;
				ADR_PRE34: rdat_d = pre34_q;
				ADR_LOAD: rdat_d = load_q;
				ADR_STATUS: rdat_d = {24'h000000, motor_q, state_q == ST_LOCKOUT, auto_q,
					local_q, trip_q, sleep_out_q, out_rev_q, state_q == ST_RUN};
				ADR_FREQ: rdat_d = {16'h0000, rp.freq};
				ADR_VALUE: rdat_d = dval_q;
				default: rdat_d = 32'h00000000;
			endcase
		end
		// Writes land at the edge where the master sees ack, as classic cycles expect
		if (WB_CYC_I && WB_STB_I && ack_q) begin
			if (WB_WE_I) begin
				case (WB_ADR_I)
					ADR_CTRL: ctrl_d = wb_merge(ctrl_q, WB_DAT_I, WB_SEL_I);
					ADR_DISP: disp_d = wb_merge(disp_q, WB_DAT_I, WB_SEL_I);
					ADR_RATES: rates_d = wb_merge(rates_q, WB_DAT_I, WB_SEL_I);
					ADR_SLEEP: sleep_d = wb_merge(sleep_q, WB_DAT_I, WB_SEL_I);
					ADR_PRE12: pre12_d = wb_merge(pre12_q, WB_DAT_I, WB_SEL_I);
					ADR_PRE34: pre34_d = wb_merge(pre34_q, WB_DAT_I, WB_SEL_I);
					ADR_LOAD: load_d = wb_merge(load_q, WB_DAT_I, WB_SEL_I);
					ADR_STATUS: if (WB_SEL_I[0] && WB_DAT_I[ST_TRIP_BIT]) trip_d = 1'b0;
					default: ;
				endcase
			end
		end
		// Trip set wins over a clear in the same cycle
		if (ol_fire) trip_d = 1'b1;
		// Prescaled tick for every timer
		tick_d = (pre_q == PRE_LAST);
		pre_d = tick_d ? '0 : pre_q + 1'b1;
		ol_cnt_d = !over ? '0 : (tick_q ? ol_cnt_q + 1'b1 : ol_cnt_q);
		fwd_prev_d = FORWARD_RUN_INPUT;
		rev_prev_d = remote_rev;
		local_d = local_mode;
		// Direction key only when both directions may be chosen
		dir_req_d = (KEY_DIRECTION && local_mode && dir_lim == DIR_BOTH) ? !dir_req_q
			: dir_req_q;
		// Speed control method
		case (method)
			SPD_MANUAL: auto_d = 1'b0;
			SPD_AUTO: auto_d = 1'b1;
			SPD_BOTH: auto_d = (KEY_AUTO_MANUAL && local_mode) ? !auto_q : auto_q;
			default: auto_d = auto_q;
		endcase
		// Run sequencing
		state_d = state_q;
		out_rev_d = out_rev_q;
		lock_cnt_d = '0;
		sleep_cnt_d = '0;
		case (state_q)
			ST_STOP: begin
				out_rev_d = dir_want;
				if (start_ok) state_d = (cmd_speed < thresh) ? ST_SLEEP : ST_RUN;
			end
			ST_RUN: begin
				// Reverse only once the output has reached zero
				if (dir_want != out_rev_q && rp.at_zero) out_rev_d = dir_want;
				// Count while low, restart when speed recovers
				if (cmd_speed < thresh) begin
					sleep_cnt_d = tick_q ? sleep_cnt_q + 1'b1 : sleep_cnt_q;
				end
				if (stop_req) begin
					state_d = (stop_mode == STOP_COAST) ? ST_STOP : ST_STOPPING;
				end else if (cmd_speed < thresh && sleep_cnt_q >= sleep_q[31:16]) begin
					state_d = ST_SLEEP;
				end
			end
			ST_STOPPING: begin
				if (rp.at_zero) begin
					state_d = (stop_mode == STOP_RAMP) ? ST_LOCKOUT : ST_STOP;
				end
			end
			ST_LOCKOUT: begin
				// Starts are refused until the lockout has run out
				lock_cnt_d = tick_q ? lock_cnt_q + 1'b1 : lock_cnt_q;
				if (tick_q && lock_cnt_q == LOCK_LAST) state_d = ST_STOP;
			end
			ST_SLEEP: begin
				if (stop_req) state_d = ST_STOP;
				else if ({1'b0, cmd_speed} >= wake_lvl) state_d = ST_RUN;
			end
			default: state_d = ST_STOP;
		endcase
		// Trip coasts the motor whatever the state
		if (ol_fire || trip_q) state_d = ST_STOP;
		sleep_out_d = (state_d == ST_SLEEP);
		motor_d = (state_d == ST_RUN) || (state_d == ST_STOPPING) ||
			(state_d == ST_SLEEP && !rp.at_zero);
		// Display scaling and decimal point
		dunit_d = eff_units;
		if (eff_units == U_HERTZ || eff_units == U_PCT_HZ) begin
			dval_d = {16'h0000, rp.freq};
			ddp_d = HZ_DECIMALS;
		end else begin
			dval_d = 32'(rp.freq * disp_q[15:0]) / PCT_DIV;
			ddp_d = disp_q[DSP_DP +: 3];
		end
	end

	// State registers
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			ctrl_q <= CTRL_RST;
			disp_q <= DISP_RST;
			rates_q <= RATES_RST;
			sleep_q <= ZERO_RST;
			pre12_q <= ZERO_RST;
			pre34_q <= ZERO_RST;
			load_q <= LOAD_RST;
			ack_q <= 1'b0;
			rdat_q <= '0;
			state_q <= ST_STOP;
			out_rev_q <= 1'b0;
			dir_req_q <= 1'b0;
			auto_q <= 1'b0;
			trip_q <= 1'b0;
			local_q <= 1'b0;
			sleep_out_q <= 1'b0;
			motor_q <= 1'b0;
			fwd_prev_q <= 1'b0;
			rev_prev_q <= 1'b0;
			pre_q <= '0;
			tick_q <= 1'b0;
			lock_cnt_q <= '0;
			sleep_cnt_q <= '0;
			ol_cnt_q <= '0;
			dval_q <= '0;
			ddp_q <= '0;
			dunit_q <= '0;
		end else begin
			ctrl_q <= ctrl_d;
			disp_q <= disp_d;
			rates_q <= rates_d;
			sleep_q <= sleep_d;
			pre12_q <= pre12_d;
			pre34_q <= pre34_d;
			load_q <= load_d;
			ack_q <= ack_d;
			rdat_q <= rdat_d;
			state_q <= state_d;
			out_rev_q <= out_rev_d;
			dir_req_q <= dir_req_d;
			auto_q <= auto_d;
			trip_q <= trip_d;
			local_q <= local_d;
			sleep_out_q <= sleep_out_d;
			motor_q <= motor_d;
			fwd_prev_q <= fwd_prev_d;
			rev_prev_q <= rev_prev_d;
			pre_q <= pre_d;
			tick_q <= tick_d;
			lock_cnt_q <= lock_cnt_d;
			sleep_cnt_q <= sleep_cnt_d;
			ol_cnt_q <= ol_cnt_d;
			dval_q <= dval_d;
			ddp_q <= ddp_d;
			dunit_q <= dunit_d;
		end
	end

	assign WB_DAT_O = rdat_q;
	assign WB_ACK_O = ack_q;
	assign MOTOR_ENABLE = motor_q;
	assign OUTPUT_FREQ = rp.freq;
	assign OUTPUT_REVERSE = out_rev_q;
	assign SLEEP_ACTIVE = sleep_out_q;
	assign OVERLOAD_TRIP = trip_q;
	assign LOCAL_ACTIVE = local_q;
	assign AUTO_ACTIVE = auto_q;
	assign DISPLAY_VALUE = dval_q;
	assign DISPLAY_DECIMAL = ddp_q;
	assign DISPLAY_UNITS = dunit_q;

	// Checks
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);
	sequence s_ramp_done(stop_mode_t m);
		state_q == ST_STOPPING && rp.at_zero && stop_mode == m && !trip_q && !ol_fire;
	endsequence
	a_coast_cuts_output: assert property ((state_q == ST_RUN && stop_req && !trip_q &&
		stop_mode == STOP_COAST) |=> (!MOTOR_ENABLE && OUTPUT_FREQ == 16'h0000))
		else $error("coast stop left output on");
	a_ramp_lockout_entry: assert property (s_ramp_done(STOP_RAMP) |=> state_q == ST_LOCKOUT)
		else $error("ramp stop skipped lockout");
	a_ramp2_no_lockout: assert property (s_ramp_done(STOP_RAMP2) |=> state_q == ST_STOP)
		else $error("second ramp stop locked out");
	a_forward_only_dir: assert property (dir_lim == DIR_FWD |-> !dir_want)
		else $error("reverse wanted under forward limit");
	a_reverse_only_dir: assert property (dir_lim == DIR_REV |-> dir_want)
		else $error("forward wanted under reverse limit");
	a_reversal_at_zero: assert property ($changed(OUTPUT_REVERSE) |->
		$past(OUTPUT_FREQ) == 16'h0000)
		else $error("direction flipped at speed");
	a_manual_method_fixed: assert property (method == SPD_MANUAL |=> !AUTO_ACTIVE)
		else $error("auto active under manual method");
	a_wake_on_hysteresis: assert property ((state_q == ST_SLEEP && !stop_req && !trip_q &&
		!ol_fire && {1'b0, cmd_speed} >= wake_lvl) |=> (state_q == ST_RUN && !SLEEP_ACTIVE))
		else $error("no wake above hysteresis");
	a_start_sleeps_at_once: assert property ((state_q == ST_STOP && start_ok && !ol_fire &&
		cmd_speed < thresh) |=> SLEEP_ACTIVE)
		else $error("low-speed start did not sleep");
	a_overload_trips: assert property (ol_fire |=> OVERLOAD_TRIP ##1 !MOTOR_ENABLE)
		else $error("overload did not trip");
	// The full minute is too long to reach in a test, so the count itself is guarded
	a_overload_counts: assert property ((over && tick_q && !ol_fire) |=>
		ol_cnt_q == $past(ol_cnt_q) + 16'h0001)
		else $error("overload timer did not count");
endmodule : drive_command_and_sleep_control

/* File: tb/keypad_terminal_model.sv */
`timescale 1ns/1ns
// Operator keypad and terminal strip as seen by the drive
module keypad_terminal_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Operator actions, levels from the bench
	input wire logic [3:0] press,
	input wire logic [4:0] contacts,
	// Key pulses and contact levels
	output logic [3:0] keys,
	output logic [4:0] lines
);
	logic [3:0] press_q; // Last held keys
	// A held key yields one pulse only; a level would toggle settings every cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			press_q <= 4'h0;
			keys <= 4'h0;
			lines <= 5'h00;
		end else begin
			press_q <= press;
			keys <= press & ~press_q;
			lines <= contacts;
		end
	end
endmodule : keypad_terminal_model

/* File: tb/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
	import drive_cmd_pkg::*;
	logic clk = 1'b0; // System clock
	logic rst_n = 1'b0; // Reset, active low
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h00000000, rdat, q, dval;
	logic [2:0] ddp, dun;
	logic ack;
	logic [3:0] press = 4'h0, keys;
	logic [4:0] contacts = 5'h10, lines;
	logic [15:0] spd = 16'h0400;
	logic men, orev, slp, otrip, loc, aut;
	logic [15:0] freq;
	int n_errors = 0;
	int samples_checked = 0;
	int n;
	// Reset values and an unmapped place
	logic [39:0] rows [6] = '{{ADR_CTRL, CTRL_RST}, {ADR_DISP, DISP_RST}, {ADR_RATES, RATES_RST},
		{ADR_LOAD, LOAD_RST}, {ADR_SLEEP, ZERO_RST}, {8'h30, 32'h00000000}};
	// Short tick keeps ramps and timers brief
	drive_command_and_sleep_control #(.TICK_CYCLES_P(4)) uut (.SYS_CLK(clk), .RST_N(rst_n),
		.WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF),
		.WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .KEY_START(keys[0]),
		.KEY_STOP(keys[1]), .KEY_DIRECTION(keys[2]), .KEY_AUTO_MANUAL(keys[3]),
		.KEY_SPEED(spd), .FORWARD_RUN_INPUT(lines[0]), .REVERSE_FUNCTION_INPUT(lines[1]),
		.FIRST_FUNCTION_INPUT(lines[2]), .SECOND_FUNCTION_INPUT(lines[3]),
		.TERMINAL_HALT_INPUT(lines[4]), .VOLTAGE_SPEED_INPUT(16'h0200),
		.CURRENT_LOOP_SPEED_INPUT(16'h0300), .LOAD_PERCENT(16'h0032), .MOTOR_ENABLE(men),
		.OUTPUT_FREQ(freq), .OUTPUT_REVERSE(orev), .SLEEP_ACTIVE(slp), .OVERLOAD_TRIP(otrip),
		.LOCAL_ACTIVE(loc), .AUTO_ACTIVE(aut), .DISPLAY_VALUE(dval), .DISPLAY_DECIMAL(ddp),
		.DISPLAY_UNITS(dun));
	keypad_terminal_model pm (.clk(clk), .rst_n(rst_n), .press(press), .contacts(contacts),
		.keys(keys), .lines(lines));
	// Clock, 4 ns period
	always #2 clk = ~clk;
	// Classic single cycle; the answer is awaited, never assumed
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (ack !== 1'b1 && k < 20);
		if (ack !== 1'b1) begin
			n_errors++;
			$display("mismatch ack expected 1 seen %b", ack);
		end
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk);
	endtask : wb
	// Compare one result
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// One key press
	task key(input int b);
		press[b] <= 1'b1;
		@(posedge clk);
		press[b] <= 1'b0;
		@(posedge clk);
	endtask : key
	// Verdict and end of run
	task wrap_up();
		if (n_errors == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : wrap_up
	// Watchdog, far beyond the few thousand cycles expected
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		wrap_up();
	end
	// Main sequence
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		foreach (rows[i]) begin
			wb(1'b0, rows[i][39:32], 32'h00000000);
			chk("reg", rows[i][31:0], q);
		end
		wb(1'b1, ADR_RATES, 32'h01000100);
		key(0);
		for (n = 0; n < 60 && freq !== 16'h0400; n++) @(posedge clk);
		chk("freq", 32'h00000400, {16'h0000, freq});
		chk("local", 32'h00000001, {31'h0, loc});
		// Display scaling, then both unit fallbacks
		wb(1'b1, ADR_DISP, 32'h00010BB8);
		wb(1'b1, ADR_CTRL, 32'h00100000);
		repeat (3) @(posedge clk);
		chk("disp", 32'h00007800, dval);
		chk("dp units", 32'h0000000A, {26'h0, ddp, dun});
		wb(1'b1, ADR_CTRL, 32'h00240000);
		repeat (3) @(posedge clk);
		chk("disp", 32'h00000400, dval);
		chk("dp units", 32'h00000010, {26'h0, ddp, dun});
		wb(1'b1, ADR_CTRL, 32'h00140010);
		repeat (3) @(posedge clk);
		chk("dp units", 32'h0000000B, {26'h0, ddp, dun});
		chk("auto", 32'h00010400, {15'h0, aut, freq});
		// Toggle key works when both methods are allowed
		wb(1'b1, ADR_CTRL, 32'h00000020);
		key(3);
		repeat (2) @(posedge clk);
		chk("toggle", 32'h00000000, {31'h0, aut});
		// Both directions: keypad reversal passes through zero
		wb(1'b1, ADR_CTRL, 32'h00000008);
		key(2);
		repeat (60) @(posedge clk);
		chk("reverse", 32'h00010400, {15'h0, orev, freq});
		// Forward limit overrides the reverse choice still held
		wb(1'b1, ADR_CTRL, 32'h00000000);
		key(2);
		repeat (60) @(posedge clk);
		chk("rev", 32'h00000000, {31'h0, orev});
		key(1);
		repeat (3) @(posedge clk);
		chk("coast", 32'h00000000, {15'h0, men, freq});
		// Ramp stop with lockout, then without
		for (int m = 1; m < 3; m++) begin
			wb(1'b1, ADR_CTRL, 32'(m));
			key(0);
			for (n = 0; n < 60 && freq !== 16'h0400; n++) @(posedge clk);
			key(1);
			repeat (3) @(posedge clk);
			chk("ramping", 32'h00000001, {31'h0, freq != 16'h0000});
			for (n = 0; n < 60 && freq !== 16'h0000; n++) @(posedge clk);
			wb(1'b0, ADR_STATUS, 32'h00000000);
			chk("lock", 32'(m == 1), {31'h0, q[6]});
			key(0);
			repeat (30) @(posedge clk);
			chk("restart", 32'(m == 2), {31'h0, freq == 16'h0400});
			repeat (900) @(posedge clk);
		end
		// Sleep after the delay, wake only past the margin
		wb(1'b1, ADR_SLEEP, 32'h00101000);
		for (n = 0; n < 200 && slp !== 1'b1; n++) @(posedge clk);
		chk("sleep", 32'h00000001, {31'h0, slp});
		spd <= 16'h1000 + WAKE_HYST[15:0] - 16'h0001;
		repeat (40) @(posedge clk);
		chk("doze", 32'h00000001, {31'h0, slp});
		spd <= 16'h1000 + WAKE_HYST[15:0];
		repeat (10) @(posedge clk);
		chk("wake", 32'h00000000, {31'h0, slp});
		// Terminal strip: local select, halt contact, run-backward
		wb(1'b1, ADR_SLEEP, 32'h00000000);
		wb(1'b1, ADR_LOAD, 32'h0000012C);
		wb(1'b1, ADR_CTRL, 32'h00000900);
		repeat (3) @(posedge clk);
		chk("local", 32'h00000000, {31'h0, loc});
		contacts <= 5'h14;
		repeat (3) @(posedge clk);
		chk("local", 32'h00000001, {31'h0, loc});
		contacts <= 5'h00;
		repeat (3) @(posedge clk);
		chk("halt", 32'h00000000, {31'h0, men});
		// Halt stays open; a low-speed start must sleep at once
		wb(1'b1, ADR_SLEEP, 32'h0000FFFF);
		wb(1'b1, ADR_CTRL, 32'h00028900);
		contacts <= 5'h01;
		repeat (30) @(posedge clk);
		chk("run back", 32'h00000001, {31'h0, slp});
		chk("trip", 32'h00000000, {31'h0, otrip});
		// Reset in mid-run
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		chk("reset", 32'h00000000, {29'h0, men, otrip, slp});
		rst_n <= 1'b1;
		@(posedge clk);
		wb(1'b0, ADR_CTRL, 32'h00000000);
		chk("reg", CTRL_RST, q);
		wrap_up();
	end
endmodule : tb_top
